// ### rtl/flash_spi_pkg.sv
package flash_spi_pkg;
  // ****************************************
  // Link and buffer sizes
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_DUAL = 3'h2;
  localparam logic [7:0] IDLE_FILL = 8'hff;
  // ****************************************
  // Erase granularities, last offset in a unit
  // ****************************************
  localparam logic [15:0] SPAN_PAGE = 16'h00ff;
  localparam logic [15:0] SPAN_4K = 16'h0fff;
  localparam logic [15:0] SPAN_32K = 16'h7fff;
  localparam logic [15:0] SPAN_CHIP = 16'hffff;
  localparam int ERASE_CYCLES_DEF = 64;

  typedef enum logic [3:0] {
    ERASE_PAGE = 4'h1,
    ERASE_BLK4K = 4'h2,
    ERASE_BLK32K = 4'h4,
    ERASE_CHIP = 4'h8
  } erase_kind_e;

  typedef enum logic [1:0] {
    ER_IDLE = 2'h1,
    ER_BUSY = 2'h2
  } erase_state_e;

  typedef struct packed {
    logic dual;
    logic [7:0] data;
  } tx_word_s;

  typedef struct packed {
    erase_kind_e kind;
    logic [15:0] addr;
  } erase_req_s;
endpackage

// ### rtl/bit_sync.sv
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic [2:0] ff_q;
  logic [2:0] ff_d;
  logic q_d;

  // ****************************************
  // Three stages, change taken when last two agree
  // ****************************************
  always_comb begin
    ff_d = {ff_q[1:0], d_i};
    q_d = (ff_q[1] == ff_q[2]) ? ff_q[2] : q_o;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ff_q <= {3{RST_VAL}};
      q_o <= RST_VAL;
    end else begin
      ff_q <= ff_d;
      q_o <= q_d;
    end
  end
endmodule

// ### rtl/stream_fifo.sv
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_d = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

// ### rtl/serial_flash_spi_front_end.sv
// Overview of operation
// - Pause input low freezes transfer state; transfer resumes where it stopped.
// - During pause, clock edges and input data ignored, output lanes released.
// - Pause never disturbs a running self-timed erase.
// - Lock and pause inputs have no internal pull-up; left open they float.
// - Write-lock input low gates region locking.
// - Erase in page, 4K block, 32K block and whole-array units.
// - Only clock modes 0 and 3 are supported by both ends.
// - Input sampled on rising clock edges, output changed on falling edges.
// - Dual read shifts out two bits per clock.
// - Dual read turns the input lane into a second output.
// - Operations start on select falling and end on select rising.
// - Output lanes released whenever chip select is high.
// - Every byte moves most significant bit first.
module serial_flash_spi_front_end
  import flash_spi_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic dual_lane_low_i,
  output logic dual_lane_low_o,
  output logic dual_lane_low_oe_o,
  output logic dual_lane_high_o,
  output logic dual_lane_high_oe_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [flash_spi_pkg::BYTE_W-1:0] rx_data_o,
  output logic rx_space_o,
  output logic rx_drop_o,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire flash_spi_pkg::tx_word_s tx_word_i,
  output logic frame_start_o,
  output logic frame_end_o,
  input wire logic protect_i,
  output logic region_locked_o,
  input wire logic erase_start_i,
  input wire flash_spi_pkg::erase_req_s erase_req_i,
  output logic erase_busy_o,
  output logic erase_refused_o,
  output logic [flash_spi_pkg::ADDR_W-1:0] erase_base_o,
  output logic [flash_spi_pkg::ADDR_W-1:0] erase_last_o
);
  import flash_spi_pkg::*;

  function automatic logic [15:0] span_of(input erase_kind_e k);
    case (k)
      ERASE_PAGE: span_of = SPAN_PAGE;
      ERASE_BLK4K: span_of = SPAN_4K;
      ERASE_BLK32K: span_of = SPAN_32K;
      default: span_of = SPAN_CHIP;
    endcase
  endfunction

  // ****************************************
  // Link receive, rising clock edges
  // ****************************************
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rise_seen_q;
  logic [7:0] rx_byte_q, rx_byte_d;
  logic rx_tog_q, rx_tog_d;
  logic dual_q, dual_d;

  always_comb begin
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    rx_byte_d = rx_byte_q;
    rx_tog_d = rx_tog_q;
    if (hold_n_i) begin
      rx_sh_d = {rx_sh_q[6:0], dual_lane_low_i};
      rx_cnt_d = rx_cnt_q + 3'h1;
      if (rx_cnt_q == BIT_LAST && !dual_q) begin
        rx_byte_d = {rx_sh_q[6:0], dual_lane_low_i};
        rx_tog_d = ~rx_tog_q;
      end
    end
  end

  // Select high clears bit position; a pause does not
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
      rise_seen_q <= 1'b0;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rise_seen_q <= rise_seen_q | hold_n_i;
    end
  end

  always_ff @(posedge sck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_byte_q <= '0;
      rx_tog_q <= 1'b0;
    end else begin
      rx_byte_q <= rx_byte_d;
      rx_tog_q <= rx_tog_d;
    end
  end

  // ****************************************
  // Link transmit, falling clock edges
  // ****************************************
  tx_word_s tx_word_q, tx_word_d;
  logic tx_req_q, tx_req_d;
  logic tx_req_s;
  logic tx_ack_q, tx_ack_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [2:0] tx_cnt_q, tx_cnt_d;
  logic drive_q, drive_d;
  logic load;

  bit_sync #(.RST_VAL(1'b0)) u_req_sync (
    .clk_i(sck_i),
    .reset_n_i(reset_n_i),
    .d_i(tx_req_q),
    .q_o(tx_req_s)
  );

  always_comb begin
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    dual_d = dual_q;
    drive_d = drive_q;
    tx_ack_d = tx_ack_q;
    load = 1'b0;
    // Mode 3 leading falling edge is skipped
    if (hold_n_i && rise_seen_q) begin
      if (tx_cnt_q == '0) begin
        load = (tx_req_s != tx_ack_q);
        tx_sh_d = load ? tx_word_q.data : IDLE_FILL;
        dual_d = load && tx_word_q.dual;
        drive_d = drive_q | load;
        tx_ack_d = load ? tx_req_s : tx_ack_q;
        tx_cnt_d = (load && tx_word_q.dual) ? STEP_DUAL : STEP_SINGLE;
      end else if (dual_q) begin
        tx_sh_d = {tx_sh_q[5:0], 2'b00};
        tx_cnt_d = tx_cnt_q + STEP_DUAL;
      end else begin
        tx_sh_d = {tx_sh_q[6:0], 1'b0};
        tx_cnt_d = tx_cnt_q + STEP_SINGLE;
      end
    end
  end

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_sh_q <= IDLE_FILL;
      tx_cnt_q <= STEP_SINGLE; // First fall follows bit 7 in, so byte ends on eighth fall
      dual_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      dual_q <= dual_d;
      drive_q <= drive_d;
    end
  end

  always_ff @(negedge sck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_ack_q <= 1'b0;
    end else begin
      tx_ack_q <= tx_ack_d;
    end
  end

  assign dual_lane_high_o = tx_sh_q[7];
  assign dual_lane_low_o = tx_sh_q[6];
  assign dual_lane_high_oe_o = !cs_n_i && hold_n_i && drive_q;
  assign dual_lane_low_oe_o = !cs_n_i && hold_n_i && drive_q && dual_q;

  // ****************************************
  // System side crossings
  // ****************************************
  logic cs_n_s, wp_n_s, rx_tog_s, tx_ack_s;

  bit_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i(cs_n_i),
    .q_o(cs_n_s)
  );
  bit_sync #(.RST_VAL(1'b1)) u_wp_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i(wp_n_i),
    .q_o(wp_n_s)
  );
  bit_sync #(.RST_VAL(1'b0)) u_rx_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i(rx_tog_q),
    .q_o(rx_tog_s)
  );
  bit_sync #(.RST_VAL(1'b0)) u_ack_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i(tx_ack_q),
    .q_o(tx_ack_s)
  );

  // ****************************************
  // Receive buffer, frame edges, transmit handshake
  // ****************************************
  logic rx_seen_q, rx_seen_d, rx_push, cs_prev_q;
  logic frame_start_d, frame_end_d, rx_drop_d;

  stream_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_space_o),
    .in_data_i(rx_byte_q),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  assign tx_ready_o = (tx_req_q == tx_ack_s);

  always_comb begin
    rx_push = (rx_tog_s != rx_seen_q);
    rx_seen_d = rx_tog_s;
    rx_drop_d = rx_push && !rx_space_o;
    frame_start_d = cs_prev_q && !cs_n_s;
    frame_end_d = !cs_prev_q && cs_n_s;
    tx_req_d = (tx_valid_i && tx_ready_o) ? ~tx_req_q : tx_req_q;
    tx_word_d = (tx_valid_i && tx_ready_o) ? tx_word_i : tx_word_q;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_seen_q <= 1'b0;
      cs_prev_q <= 1'b1;
      frame_start_o <= 1'b0;
      frame_end_o <= 1'b0;
      rx_drop_o <= 1'b0;
      tx_req_q <= 1'b0;
      tx_word_q <= '0;
    end else begin
      rx_seen_q <= rx_seen_d;
      cs_prev_q <= cs_n_s;
      frame_start_o <= frame_start_d;
      frame_end_o <= frame_end_d;
      rx_drop_o <= rx_drop_d;
      tx_req_q <= tx_req_d;
      tx_word_q <= tx_word_d;
    end
  end

  // ****************************************
  // Region lock and self-timed erase
  // ****************************************
  erase_state_e er_q, er_d;
  logic [31:0] er_cnt_q, er_cnt_d;
  logic [15:0] base_d, last_d;
  logic locked_d, refused_d;

  always_comb begin
    locked_d = protect_i && !wp_n_s;
    er_d = er_q;
    er_cnt_d = er_cnt_q;
    base_d = erase_base_o;
    last_d = erase_last_o;
    refused_d = erase_start_i && (region_locked_o || er_q != ER_IDLE);
    case (er_q)
      ER_IDLE: begin
        if (erase_start_i && !region_locked_o) begin
          base_d = erase_req_i.addr & ~span_of(erase_req_i.kind);
          last_d = erase_req_i.addr | span_of(erase_req_i.kind);
          er_cnt_d = 32'(ERASE_CYCLES - 1);
          er_d = ER_BUSY;
        end
      end
      ER_BUSY: begin
        // Runs on the system clock only, so a pause cannot stall it
        if (er_cnt_q == '0) begin
          er_d = ER_IDLE;
        end else begin
          er_cnt_d = er_cnt_q - 32'h1;
        end
      end
      default: er_d = ER_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      er_q <= ER_IDLE;
      er_cnt_q <= '0;
      erase_base_o <= '0;
      erase_last_o <= '0;
      region_locked_o <= 1'b0;
      erase_refused_o <= 1'b0;
    end else begin
      er_q <= er_d;
      er_cnt_q <= er_cnt_d;
      erase_base_o <= base_d;
      erase_last_o <= last_d;
      region_locked_o <= locked_d;
      erase_refused_o <= refused_d;
    end
  end

  assign erase_busy_o = (er_q == ER_BUSY);

  // ****************************************
  // Checks
  // ****************************************
  property p_hiz_desel;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      cs_n_i |-> !dual_lane_high_oe_o && !dual_lane_low_oe_o;
  endproperty
  a_hiz_desel: assert property (p_hiz_desel) else $error("lanes driven while deselected");

  property p_pause_hiz;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !hold_n_i |-> !dual_lane_high_oe_o && !dual_lane_low_oe_o;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("lanes driven during pause");

  property p_low_lane;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      dual_lane_low_oe_o |-> dual_lane_high_oe_o && dual_q;
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("low lane driven outside dual");

  property p_pause_keeps;
    @(posedge sck_i) disable iff (cs_n_i || !reset_n_i)
      !hold_n_i |=> $stable(rx_cnt_q) && $stable(rx_tog_q);
  endproperty
  a_pause_keeps: assert property (p_pause_keeps) else $error("pause altered state");

  property p_byte_done;
    @(posedge sck_i) disable iff (cs_n_i || !reset_n_i)
      hold_n_i && rx_cnt_q == BIT_LAST && !dual_q |=>
        rx_tog_q != $past(rx_tog_q) && rx_cnt_q == '0;
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("byte not taken after 8 bits");

  property p_dual_step;
    @(negedge sck_i) disable iff (cs_n_i || !reset_n_i)
      hold_n_i && dual_q && tx_cnt_q != '0 |=> tx_cnt_q == $past(tx_cnt_q) + STEP_DUAL;
  endproperty
  a_dual_step: assert property (p_dual_step) else $error("dual did not move two bits");

  property p_erase_span;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      er_q == ER_IDLE && erase_start_i && !region_locked_o && erase_req_i.kind == ERASE_BLK4K
        |=> erase_busy_o && erase_last_o - erase_base_o == SPAN_4K;
  endproperty
  a_erase_span: assert property (p_erase_span) else $error("bad 4K erase range");

  property p_erase_runs;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      erase_busy_o && er_cnt_q != '0 && !hold_n_i |=> erase_busy_o;
  endproperty
  a_erase_runs: assert property (p_erase_runs) else $error("erase stopped by pause");

  property p_lock_gate;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      region_locked_o |-> $past(protect_i) && !$past(wp_n_s);
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("lock without lock input low");

  property p_frame_pulse;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      frame_start_o |=> !frame_start_o ##[1:1000] 1'b1;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame start not a pulse");

  c_dual: cover property (@(posedge clk_sys_i) dual_lane_low_oe_o);
  c_pause: cover property (@(posedge clk_sys_i) !cs_n_i && !hold_n_i);
  c_erase: cover property (@(posedge clk_sys_i) erase_busy_o ##1 !erase_busy_o);
  c_drop: cover property (@(posedge clk_sys_i) rx_drop_o);
endmodule

// ### sim/spi_host_model.sv
module spi_host_model (
  output logic cs_n_o,
  output logic sck_o,
  output logic hold_n_o,
  output logic si_pin_o,
  input wire logic low_i,
  input wire logic low_oe_i,
  input wire logic high_i,
  input wire logic high_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Host side of the four-line bus
  // ****************************************
  logic si_q;
  logic si_oe;
  logic mode3;
  logic hiz_bad;

  // Shared lane: clash reads as unknown, released lane shows inverse of last level
  assign si_pin_o = (low_oe_i && si_oe) ? 1'bx : low_oe_i ? low_i : si_oe ? si_q : ~si_q;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    hold_n_o = 1'b1;
    si_q = 1'b0;
    si_oe = 1'b1;
    mode3 = 1'b0;
    hiz_bad = 1'b0;
  end

  task automatic begin_frame(input logic m3);
    mode3 = m3;
    sck_o = m3;
    #16;
    cs_n_o = 1'b0;
    #16;
  endtask

  task automatic end_frame();
    #32;
    if (!mode3) sck_o = 1'b0;
    #16;
    cs_n_o = 1'b1;
    si_oe = 1'b1;
    #32;
  endtask

  // Pause only with select low and clock low; clock and input wiggle meanwhile
  task automatic pause();
    logic keep;
    keep = si_q;
    hold_n_o = 1'b0;
    repeat (3) begin
      #8;
      if (high_oe_i || low_oe_i) hiz_bad = 1'b1;
      sck_o = 1'b1;
      si_q = ~si_q;
      #8;
      sck_o = 1'b0;
    end
    si_q = keep;
    #8;
    hold_n_o = 1'b1;
  endtask

  // Drive on the fall, sample on the rise; undriven lanes read as unknown
  task automatic xfer(input logic [7:0] tx, input logic dual, input int pause_at,
                      output logic [7:0] rx);
    int nb;
    nb = dual ? 4 : 8;
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      sck_o = 1'b0;
      si_oe = !dual;
      si_q = tx[7-i];
      #16;
      if (i == pause_at) pause();
      #16;
      sck_o = 1'b1;
      if (dual) rx = {rx[5:0], high_oe_i ? high_i : 1'bx, low_oe_i ? low_i : 1'bx};
      else rx = {rx[6:0], high_oe_i ? high_i : 1'bx};
      #32;
    end
  endtask
endmodule

// ### sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_spi_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int EC = 4;
  typedef struct packed {
    erase_kind_e kind;
    logic [15:0] addr;
    logic [15:0] base;
    logic [15:0] last;
  } row_s;
  row_s rows [4] = '{'{ERASE_PAGE, 16'h1234, 16'h1200, 16'h12ff},
                     '{ERASE_BLK4K, 16'h5678, 16'h5000, 16'h5fff},
                     '{ERASE_BLK32K, 16'h9abc, 16'h8000, 16'hffff},
                     '{ERASE_CHIP, 16'h4321, 16'h0000, 16'hffff}};
  logic clk_sys, reset_n, cs_n, sck, hold_n, wp_n, si_pin, low_o, low_oe, high_o, high_oe;
  logic rx_valid, rx_ready, rx_space, rx_drop, tx_valid, tx_ready, frame_start, frame_end;
  logic protect, locked, erase_start, erase_busy, erase_refused;
  logic [7:0] rx_data;
  logic [7:0] hrx;
  logic [15:0] erase_base, erase_last;
  tx_word_s tx_word;
  erase_req_s erase_req;
  int error_cnt, total_checks, cyc, fs_cnt, fe_cnt, drop_cnt, n;

  serial_flash_spi_front_end #(.ERASE_CYCLES(EC)) dut (
    .clk_sys_i(clk_sys),
    .reset_n_i(reset_n),
    .sck_i(sck),
    .cs_n_i(cs_n),
    .hold_n_i(hold_n),
    .wp_n_i(wp_n),
    .dual_lane_low_i(si_pin),
    .dual_lane_low_o(low_o),
    .dual_lane_low_oe_o(low_oe),
    .dual_lane_high_o(high_o),
    .dual_lane_high_oe_o(high_oe),
    .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready),
    .rx_data_o(rx_data),
    .rx_space_o(rx_space),
    .rx_drop_o(rx_drop),
    .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready),
    .tx_word_i(tx_word),
    .frame_start_o(frame_start),
    .frame_end_o(frame_end),
    .protect_i(protect),
    .region_locked_o(locked),
    .erase_start_i(erase_start),
    .erase_req_i(erase_req),
    .erase_busy_o(erase_busy),
    .erase_refused_o(erase_refused),
    .erase_base_o(erase_base),
    .erase_last_o(erase_last)
  );

  spi_host_model host (
    .cs_n_o(cs_n),
    .sck_o(sck),
    .hold_n_o(hold_n),
    .si_pin_o(si_pin),
    .low_i(low_o),
    .low_oe_i(low_oe),
    .high_i(high_o),
    .high_oe_i(high_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    cyc++;
    if (frame_start === 1'b1) fs_cnt++;
    if (frame_end === 1'b1) fe_cnt++;
    if (rx_drop === 1'b1) drop_cnt++;
    if (cyc == 20000) begin
      check("timeout", 16'(cyc), 16'h0000);
      end_sim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic push(input logic d, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk_sys);
    #1;
    tx_word = '{d, v};
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && k < 50) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("tx_ready", tx_ready, 1'b1);
    @(posedge clk_sys);
    #1;
    tx_valid = 1'b0;
  endtask

  task automatic pop(input logic [7:0] e);
    int k;
    k = 0;
    @(posedge clk_sys);
    #1;
    while (rx_valid !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("rx_data", rx_data, e);
    rx_ready = 1'b1;
    @(posedge clk_sys);
    #1;
    rx_ready = 1'b0;
  endtask

  task automatic erase(input erase_kind_e k, input logic [15:0] a, input logic refd);
    @(posedge clk_sys);
    #1;
    erase_req = '{k, a};
    erase_start = 1'b1;
    @(posedge clk_sys);
    #1;
    erase_start = 1'b0;
    check("erase_refused", erase_refused, refd);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    protect = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_word = '{1'b0, 8'h00};
    erase_start = 1'b0;
    erase_req = '{ERASE_PAGE, 16'h0000};
    repeat (5) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    foreach (rows[i]) begin
      erase(rows[i].kind, rows[i].addr, 1'b0);
      check("erase_base", erase_base, rows[i].base);
      check("erase_last", erase_last, rows[i].last);
      n = 0;
      while (erase_busy === 1'b1 && n < 50) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check("busy_len", 16'(n), 16'(EC));
    end
    erase(ERASE_CHIP, 16'h0000, 1'b0);
    erase(ERASE_PAGE, 16'h0100, 1'b1);
    repeat (EC + 2) @(posedge clk_sys);
    #1;
    protect = 1'b1;
    wp_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check("locked", locked, 1'b1);
    erase(ERASE_PAGE, 16'h0200, 1'b1);
    wp_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check("unlocked", locked, 1'b0);
    protect = 1'b0;
    push(1'b0, 8'h3c);
    host.begin_frame(1'b0);
    host.xfer(8'ha5, 1'b0, -1, hrx);
    host.xfer(8'h00, 1'b0, -1, hrx);
    check("single_out", hrx, 8'h3c);
    host.end_frame();
    check("high_oe_idle", high_oe, 1'b0);
    pop(8'ha5);
    pop(8'h00);
    push(1'b0, 8'h69);
    host.begin_frame(1'b1);
    host.xfer(8'hc3, 1'b0, -1, hrx);
    host.xfer(8'h00, 1'b0, -1, hrx);
    check("mode3_out", hrx, 8'h69);
    host.end_frame();
    pop(8'hc3);
    pop(8'h00);
    push(1'b1, 8'hb4);
    host.begin_frame(1'b0);
    host.xfer(8'h6e, 1'b0, -1, hrx);
    host.xfer(8'h00, 1'b1, -1, hrx);
    check("dual_out", hrx, 8'hb4);
    host.end_frame();
    check("low_oe_idle", low_oe, 1'b0);
    pop(8'h6e);
    push(1'b0, 8'h5a);
    fork
      begin
        host.begin_frame(1'b0);
        host.xfer(8'h96, 1'b0, -1, hrx);
        host.xfer(8'h00, 1'b0, 3, hrx);
        host.end_frame();
        check("pause_out", hrx, 8'h5a);
      end
      begin
        wait (hold_n === 1'b0);
        erase(ERASE_BLK4K, 16'h2000, 1'b0);
        repeat (EC) @(posedge clk_sys);
        #1;
        check("busy_in_pause", {erase_busy, hold_n}, 2'b00);
      end
    join
    check("pause_hiz", host.hiz_bad, 1'b0);
    pop(8'h96);
    pop(8'h00);
    host.begin_frame(1'b0);
    for (int i = 0; i < 9; i++) host.xfer(8'h10 + 8'(i), 1'b0, -1, hrx);
    host.end_frame();
    repeat (10) @(posedge clk_sys);
    #1;
    check("rx_space", rx_space, 1'b0);
    check("drop_cnt", 16'(drop_cnt), 16'h0001);
    for (int i = 0; i < 8; i++) pop(8'h10 + 8'(i));
    check("rx_empty", rx_valid, 1'b0);
    check("frame_starts", 16'(fs_cnt), 16'h0005);
    check("frame_ends", 16'(fe_cnt), 16'h0005);
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("reset_out", {tx_ready, rx_valid, locked, erase_busy}, 4'h8);
    end_sim();
  end
endmodule
